/* File: logic/lpctl_defines.svh */
`ifndef LPCTL_DEFINES_SVH
`define LPCTL_DEFINES_SVH

// Clock period in picoseconds (100 MHz)
`define LPCTL_TCK_PS        32'd10000
`define LPCTL_CYC(ps, mn)   (((ps) + `LPCTL_TCK_PS - 32'd1) / `LPCTL_TCK_PS < (mn) ? (mn) : \
                             ((ps) + `LPCTL_TCK_PS - 32'd1) / `LPCTL_TCK_PS)

// Core timing minimums in picoseconds, as printed in ns
`define LPCTL_TRCD_PS       32'd18000
`define LPCTL_TRPPB_PS      32'd18000
`define LPCTL_TRPAB_PS      32'd21000
`define LPCTL_TRAS_PS       32'd42000
`define LPCTL_TWR_PS        32'd15000
`define LPCTL_TWTR_PS       32'd10000
`define LPCTL_TRTP_PS       32'd7500
`define LPCTL_TRRD_PS       32'd10000
`define LPCTL_TFAW_PS       32'd60000
`define LPCTL_TRFCAB_PS     32'd130000
`define LPCTL_TXP_PS        32'd7500
`define LPCTL_TXSR_PS       (`LPCTL_TRFCAB_PS + 32'd10000)
`define LPCTL_TCKESR_PS     32'd15000

// Cycle counts derived from the times above; tCCD, tCKE, tMRW and tMRR are fixed counts
`define LPCTL_TRCD_CYC      `LPCTL_CYC(`LPCTL_TRCD_PS, 32'd3)
`define LPCTL_TRPPB_CYC     `LPCTL_CYC(`LPCTL_TRPPB_PS, 32'd3)
`define LPCTL_TRPAB_CYC     `LPCTL_CYC(`LPCTL_TRPAB_PS, 32'd3)
`define LPCTL_TRAS_CYC      `LPCTL_CYC(`LPCTL_TRAS_PS, 32'd3)
`define LPCTL_TWR_CYC       `LPCTL_CYC(`LPCTL_TWR_PS, 32'd3)
`define LPCTL_TWTR_CYC      `LPCTL_CYC(`LPCTL_TWTR_PS, 32'd2)
`define LPCTL_TRTP_CYC      `LPCTL_CYC(`LPCTL_TRTP_PS, 32'd2)
`define LPCTL_TRRD_CYC      `LPCTL_CYC(`LPCTL_TRRD_PS, 32'd2)
`define LPCTL_TFAW_CYC      `LPCTL_CYC(`LPCTL_TFAW_PS, 32'd8)
`define LPCTL_TRFC_CYC      `LPCTL_CYC(`LPCTL_TRFCAB_PS, 32'd1)
`define LPCTL_TXP_CYC       `LPCTL_CYC(`LPCTL_TXP_PS, 32'd2)
`define LPCTL_TXSR_CYC      `LPCTL_CYC(`LPCTL_TXSR_PS, 32'd2)
`define LPCTL_TCKESR_CYC    `LPCTL_CYC(`LPCTL_TCKESR_PS, 32'd3)
`define LPCTL_TCCD_CYC      32'd2
`define LPCTL_TCKE_CYC      32'd3
`define LPCTL_TMRW_CYC      32'd5
`define LPCTL_TMRR_CYC      32'd2
// Row open limit 70 us, refresh interval 3.9 us, deep power-down 500 us
`define LPCTL_TRASMAX_NS    32'd70000
`define LPCTL_TREFI_NS      32'd3900
`define LPCTL_TDPD_NS       32'd500000

// Latencies for the grade this controller drives (400 grade at 100 MHz)
`define LPCTL_RL_CYC        32'd3
`define LPCTL_WL_CYC        32'd1
`define LPCTL_BL_BEATS      32'd4

// Command encodings on rising-edge CA0..CA3
`define LPCTL_ENC_MRW       4'h0
`define LPCTL_ENC_ACT_BITS  2'h2
`define LPCTL_ENC_WR        3'h1
`define LPCTL_ENC_RD        3'h5
`define LPCTL_ENC_PRE       4'hB
`define LPCTL_ENC_REFAB     4'hC
`define LPCTL_ENC_NOP       4'h7
`define LPCTL_ENC_SELF      4'h4
`define LPCTL_ENC_DPD       4'h3

// Field widths in the user request word, and the write FIFO depth
`define LPCTL_ROW_W         14
`define LPCTL_COL_W         10
`define LPCTL_BANK_W        3
`define LPCTL_FIFO_DEPTH    16

`endif

/* File: logic/lpctl_pkg.sv */
`include "lpctl_defines.svh"

package lpctl_pkg;
   typedef enum logic [2:0] {
      LPCTL_OP_READ,
      LPCTL_OP_WRITE,
      LPCTL_OP_MRW,
      LPCTL_OP_REFRESH,
      LPCTL_OP_SELFREF,
      LPCTL_OP_DEEPPD,
      LPCTL_OP_WAKE
   } lpctl_op_t;

   typedef struct packed {
      lpctl_op_t                  op;
      logic                       autoPre;
      logic [`LPCTL_BANK_W-1:0]   bank;
      logic [`LPCTL_ROW_W-1:0]    row;
      logic [`LPCTL_COL_W-1:0]    col;
      logic [7:0]                 mrAddr;
      logic [7:0]                 mrData;
   } lpctl_req_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  mask;
   } lpctl_beat_t;

   typedef struct packed {
      logic       csn;
      logic       cke;
      logic [9:0] caRise;
      logic [9:0] caFall;
   } lpctl_ca_t;
endpackage

/* File: logic/lpctl_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module lpctl_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,     // System clock
   input  wire logic             rstn,     // Async reset, active low
   input  wire logic             inValid,  // Write side valid
   output logic                  inReady,  // Write side ready
   input  wire logic [WIDTH-1:0] inData,   // Write side data
   output logic                  outValid, // Read side valid
   input  wire logic             outReady, // Read side ready
   output logic      [WIDTH-1:0] outData   // Read side data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   wire              doWr = inValid && inReady;
   wire              doRd = outValid && outReady;

   assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
   assign outValid = wrPtr != rdPtr;
   assign outData  = mem[rdPtr[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (doWr) mem[wrPtr[AW-1:0]] <= inData;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (doWr) wrPtr <= wrPtr + 1'b1;
         if (doRd) rdPtr <= rdPtr + 1'b1;
      end
   end
endmodule

`default_nettype wire

/* File: logic/lpctl_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpctl_defines.svh"

module lpctl_ctrl #(
   parameter int REFI_CYC   = `LPCTL_TREFI_NS * 32'd1000 / `LPCTL_TCK_PS,
   parameter int RASMAX_CYC = `LPCTL_TRASMAX_NS * 32'd1000 / `LPCTL_TCK_PS,
   parameter int DPD_CYC    = `LPCTL_TDPD_NS * 32'd1000 / `LPCTL_TCK_PS
) (
   input  wire logic                   mclk,      // System clock, 100 MHz
   input  wire logic                   rstn,      // Async reset, active low
   input  wire lpctl_pkg::lpctl_req_t  req,       // User request
   input  wire logic                   reqValid,  // Request valid
   output logic                        reqReady,  // Request taken this cycle
   input  wire lpctl_pkg::lpctl_beat_t wrBeat,    // Write data and byte mask
   input  wire logic                   wrValid,   // Write beat valid
   output logic                        wrReady,   // Write FIFO has room
   output logic [31:0]                 rdData,    // Read data
   output logic                        rdValid,   // Read data pulse
   output logic                        busy,      // Controller not idle
   output logic                        memCkEn,   // Clock enable to memory
   output logic                        memCsn,    // Chip select, low active
   output logic [9:0]                  memCaRise, // CA bits for rising edge
   output logic [9:0]                  memCaFall, // CA bits for falling edge
   output logic [31:0]                 memDqOut,  // Data out
   output logic [31:0]                 memDqOe,   // Data output enable
   input  wire logic [31:0]            memDqIn,   // Data in
   output logic [3:0]                  memMask,   // Byte masks on writes
   output logic [3:0]                  memStrobe, // Write strobe level
   output logic [3:0]                  memStrobeOe // Strobe output enable
);
   typedef enum logic [3:0] {
      S_IDLE, S_ACT, S_COL, S_PRE, S_MRW, S_REF, S_SELF, S_DPD, S_WAKE, S_WAIT
   } state_t;

   state_t                 state;
   state_t                 next_state;
   lpctl_pkg::lpctl_req_t  cur;
   logic [19:0]            waitCnt;
   logic [19:0]            refCnt;
   logic [19:0]            rasCnt;
   logic [3:0]             ckeCnt;
   logic [3:0]             actHist [4];
   logic [3:0]             colGap;
   logic [7:0]             dataPipe;
   logic [9:0]             rdPipe;
   logic [2:0]             beatCnt;
   logic [31:0]            dqS1;
   logic [31:0]            dqS2;
   logic                   lowPower;
   lpctl_pkg::lpctl_ca_t   ca;

   wire lpctl_pkg::lpctl_beat_t fifoOut;
   wire logic fifoValid;
   wire logic fifoPop = dataPipe[0] && fifoValid;

   lpctl_fifo #(.WIDTH(36), .DEPTH(`LPCTL_FIFO_DEPTH)) wrFifo (
      .mclk     (mclk),
      .rstn     (rstn),
      .inValid  (wrValid),
      .inReady  (wrReady),
      .inData   (wrBeat),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoOut)
   );

   // Time since the most recent activate bounds the four-activate window
   wire logic fawOk  = actHist[3] == 4'h0;
   wire logic rrdOk  = actHist[0] == 4'h0;
   wire logic waitOk = waitCnt == 20'h0;
   wire logic ckeOk  = ckeCnt == 4'h0;
   wire logic refDue = refCnt == 20'h0;
   wire logic rasOk  = rasCnt == 20'h0;
   wire logic colOk  = colGap == 4'h0;

   function automatic logic [19:0] cyc(input logic [31:0] n);
      cyc = n[19:0];
   endfunction

   // Encoded CA words for activate, column, mode write, precharge and refresh
   wire logic [9:0] actR = {cur.bank, cur.row[12:8], 2'h2};
   wire logic [9:0] actF = {1'b0, cur.row[13], cur.row[7:0]};
   wire logic [9:0] colR = {cur.bank, cur.col[2:1], 2'h0,
                            (cur.op == lpctl_pkg::LPCTL_OP_WRITE) ? `LPCTL_ENC_WR : `LPCTL_ENC_RD};
   wire logic [9:0] colF = {2'h0, cur.col[9:3], cur.autoPre};
   wire logic [9:0] mrwR = {cur.mrAddr[5:0], `LPCTL_ENC_MRW};
   wire logic [9:0] mrwF = {cur.mrData, cur.mrAddr[7:6]};
   wire logic [9:0] preR = {cur.bank, 2'h0, 1'b0, `LPCTL_ENC_PRE};
   wire logic [9:0] refR = {6'h00, `LPCTL_ENC_REFAB};

   wire logic canAct = waitOk && rrdOk && fawOk;
   wire logic canCol = waitOk && colOk;

   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (refDue && !lowPower) next_state = S_REF;
            else if (reqValid && !lowPower) begin
               case (req.op)
                  lpctl_pkg::LPCTL_OP_MRW:     next_state = S_MRW;
                  lpctl_pkg::LPCTL_OP_REFRESH: next_state = S_REF;
                  lpctl_pkg::LPCTL_OP_SELFREF: next_state = S_SELF;
                  lpctl_pkg::LPCTL_OP_DEEPPD:  next_state = S_DPD;
                  lpctl_pkg::LPCTL_OP_WAKE:    next_state = S_IDLE;
                  default:                     next_state = S_ACT;
               endcase
            end else if (reqValid && req.op == lpctl_pkg::LPCTL_OP_WAKE)
               next_state = S_WAKE;
         end
         S_ACT:  if (canAct) next_state = S_COL;
         S_COL:  if (canCol) next_state = S_PRE;
         S_PRE:  if (waitOk && rasOk) next_state = S_WAIT;
         // Low-power minimum time runs in waitCnt while idle, so wake waits for it
         S_WAKE: if (ckeOk && waitOk) next_state = S_WAIT;
         S_MRW, S_REF, S_SELF, S_DPD: if (waitOk && ckeOk) next_state = (state == S_SELF || state == S_DPD) ? S_IDLE : S_WAIT;
         S_WAIT: if (waitOk && dataPipe == 8'h0 && rdPipe == 10'h0) next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   wire logic enterIdle = state == S_IDLE && next_state != S_IDLE;
   assign reqReady = state == S_IDLE && reqValid && (next_state != S_IDLE || req.op == lpctl_pkg::LPCTL_OP_WAKE)
                     && !(refDue && !lowPower);
   assign busy     = state != S_IDLE;
   wire logic issueAct = state == S_ACT && canAct;
   wire logic issueCol = state == S_COL && canCol;
   wire logic issuePre = state == S_PRE && waitOk && rasOk;
   wire logic issueMrw = state == S_MRW && waitOk;
   wire logic issueRef = state == S_REF && waitOk;
   wire logic isWrite  = cur.op == lpctl_pkg::LPCTL_OP_WRITE;

   // Default command is deselect so the device sees nothing new
   always_comb begin
      ca = '{csn: 1'b1, cke: memCkEn, caRise: 10'h3FF, caFall: 10'h3FF};
      if (issueAct) ca = '{1'b0, 1'b1, actR, actF};
      else if (issueCol) ca = '{1'b0, 1'b1, colR, colF};
      else if (issuePre) ca = '{1'b0, 1'b1, preR, 10'h000};
      else if (issueMrw) ca = '{1'b0, 1'b1, mrwR, mrwF};
      else if (issueRef) ca = '{1'b0, 1'b1, refR, 10'h000};
      else if (state == S_SELF && waitOk && ckeOk && !lowPower)
         ca = '{1'b0, 1'b0, {6'h00, `LPCTL_ENC_SELF}, 10'h000};
      else if (state == S_DPD && waitOk && ckeOk && !lowPower)
         ca = '{1'b0, 1'b0, {6'h00, `LPCTL_ENC_DPD}, 10'h000};
      else if (state == S_WAKE && ckeOk && waitOk) ca.cke = 1'b1;
   end

   // Auto-precharge skips the explicit precharge; wait covers tRP anyway
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state     <= S_IDLE;
         cur       <= '0;
         waitCnt   <= 20'h0;
         refCnt    <= 20'h0;
         rasCnt    <= 20'h0;
         ckeCnt    <= 4'h0;
         colGap    <= 4'h0;
         lowPower  <= 1'b0;
         memCkEn   <= 1'b1;
         memCsn    <= 1'b1;
         memCaRise <= 10'h3FF;
         memCaFall <= 10'h3FF;
      end else begin
         state     <= next_state;
         memCkEn   <= ca.cke;
         memCsn    <= ca.csn;
         memCaRise <= ca.caRise;
         memCaFall <= ca.caFall;
         if (enterIdle) cur <= req;
         refCnt  <= issueRef ? cyc(REFI_CYC) : (refCnt != 20'h0 ? refCnt - 20'h1 : refCnt);
         colGap  <= issueCol ? 4'(`LPCTL_TCCD_CYC - 32'd1) : (colOk ? colGap : colGap - 4'h1);
         ckeCnt  <= (ca.cke != memCkEn) ? 4'(`LPCTL_TCKE_CYC - 32'd1) : (ckeOk ? ckeCnt : ckeCnt - 4'h1);
         if (issueAct) rasCnt <= cyc(`LPCTL_TRAS_CYC - 32'd1);
         else if (!rasOk) rasCnt <= rasCnt - 20'h1;
         if (issueAct) waitCnt <= cyc(`LPCTL_TRCD_CYC - 32'd1);
         else if (issueCol) begin
            if (cur.autoPre)
               waitCnt <= cyc(`LPCTL_WL_CYC + `LPCTL_BL_BEATS / 32'd2 + `LPCTL_TWR_CYC + `LPCTL_TRPPB_CYC);
            else if (isWrite)
               waitCnt <= cyc(`LPCTL_WL_CYC + `LPCTL_BL_BEATS / 32'd2 + `LPCTL_TWR_CYC);
            else
               waitCnt <= cyc(`LPCTL_BL_BEATS / 32'd2 + `LPCTL_TRTP_CYC);
         end else if (issuePre) waitCnt <= cyc(`LPCTL_TRPPB_CYC - 32'd1);
         else if (issueMrw) waitCnt <= cyc(`LPCTL_TMRW_CYC - 32'd1);
         else if (issueRef) waitCnt <= cyc(`LPCTL_TRFC_CYC - 32'd1);
         else if (state == S_SELF && ca.cke == 1'b0 && memCkEn) begin
            waitCnt  <= cyc(`LPCTL_TCKESR_CYC);
            lowPower <= 1'b1;
         end else if (state == S_DPD && ca.cke == 1'b0 && memCkEn) begin
            waitCnt  <= cyc(DPD_CYC);
            lowPower <= 1'b1;
         end else if (state == S_WAKE && ckeOk && waitOk) begin
            waitCnt  <= cyc(`LPCTL_TXSR_CYC);
            lowPower <= 1'b0;
         end else if (!waitOk) waitCnt <= waitCnt - 20'h1;
         // Auto-precharge closes the row, so the explicit precharge is skipped
         if (issueCol && cur.autoPre) state <= S_WAIT;
      end
   end

   // Activate history for spacing and the four-activate window
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gHist
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) actHist[gi] <= 4'h0;
            else if (issueAct) actHist[gi] <= (gi == 0) ? 4'(`LPCTL_TRRD_CYC - 32'd1)
                                                          : 4'(`LPCTL_TFAW_CYC - 32'd1);
            else if (actHist[gi] != 4'h0) actHist[gi] <= actHist[gi] - 4'h1;
         end
      end
   endgenerate

   // Data timing pipes: write beats at WL, read beats sampled after RL
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dataPipe <= 8'h0;
         rdPipe   <= 10'h0;
         beatCnt  <= 3'h0;
      end else begin
         dataPipe <= {1'b0, dataPipe[7:1]};
         rdPipe   <= {1'b0, rdPipe[9:1]};
         if (issueCol && isWrite) dataPipe[`LPCTL_WL_CYC + 32'd1 +: 4] <= 4'hF;
         if (issueCol && !isWrite) rdPipe[`LPCTL_RL_CYC + 32'd3 +: 4] <= 4'hF;
         if (fifoPop) beatCnt <= beatCnt + 3'h1;
      end
   end

   // Read data crosses from the pins through two flops and then the rdData register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dqS1        <= 32'h0;
         dqS2        <= 32'h0;
         rdData      <= 32'h0;
         rdValid     <= 1'b0;
         memDqOut    <= 32'h0;
         memDqOe     <= 32'h0;
         memMask     <= 4'h0;
         memStrobe   <= 4'h0;
         memStrobeOe <= 4'h0;
      end else begin
         dqS1    <= memDqIn;
         dqS2    <= dqS1;
         rdData  <= dqS2;
         rdValid <= rdPipe[0];
         // Lane i drives DQ[8i+7:8i]; an empty FIFO beat goes out masked
         memDqOut    <= fifoOut.data;
         memDqOe     <= {32{dataPipe[0]}};
         memMask     <= fifoValid ? fifoOut.mask : 4'hF;
         memStrobe   <= {4{beatCnt[0]}};
         memStrobeOe <= {4{dataPipe[0]}};
      end
   end
endmodule

`default_nettype wire

/* File: sim/lpctl_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lpctl_ctrl_checker (
   input  wire logic       mclk,      // Clock
   input  wire logic       rstn,      // Reset, low active
   input  wire logic       memCkEn,   // Clock enable
   input  wire logic       memCsn,    // Select, low active
   input  wire logic [9:0] memCaRise, // CA rising half
   input  wire logic [9:0] memCaFall  // CA falling half
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire sel   = !memCsn && memCkEn;
   // NOP shares CA0-CA2 high, so it is not counted as a command
   wire isCmd = sel && memCaRise[2:0] != 3'h7;
   wire isAct = sel && memCaRise[1:0] == 2'h2;
   wire isCol = sel && memCaRise[1:0] == 2'h1;
   wire isPre = sel && memCaRise[3:0] == 4'hB;
   wire isRef = sel && memCaRise[3:0] == 4'hC;
   wire isMrw = sel && memCaRise[3:0] == 4'h0;
   a_cke_min_hold: assert property ($changed(memCkEn) |=> $stable(memCkEn) [*2])
      else $error("clock enable level held under three cycles");
   a_col_spacing: assert property (isCol |=> !isCol)
      else $error("column commands closer than two cycles");
   a_act_to_col: assert property (isAct |=> !isCol [*2])
      else $error("column command too soon after activate");
   a_pre_to_act: assert property (isPre |=> !isAct [*2])
      else $error("activate too soon after precharge");
   a_row_open_min: assert property (isAct |=> !isPre [*4])
      else $error("row closed before minimum open time");
   a_act_spacing: assert property (isAct |=> !isAct)
      else $error("activates closer than two cycles");
   a_wake_quiet: assert property ($rose(memCkEn) |-> !isCmd ##1 !isCmd)
      else $error("command issued during wake-up delay");
   a_mrw_gap: assert property (isMrw |=> !isCmd [*4])
      else $error("command too soon after mode write");
   a_refresh_gap: assert property (isRef |=> !isCmd [*8] ##1 !isCmd [*4])
      else $error("command inside refresh cycle time");
   a_desel_idle: assert property (memCsn |-> memCaRise == 10'h3FF && memCaFall == 10'h3FF)
      else $error("deselect cycle with stray address bits");
   cover property (isMrw);
   cover property (isRef);
   cover property (isCol && memCaFall[0]);
   cover property ($fell(memCkEn));
endmodule
bind lpctl_ctrl lpctl_ctrl_checker u_chk (.mclk(mclk), .rstn(rstn), .memCkEn(memCkEn), .memCsn(memCsn),
   .memCaRise(memCaRise), .memCaFall(memCaFall));
`default_nettype wire

/* File: sim/lpctl_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpctl_defines.svh"
module lpctl_dev_model (
   input  wire logic        mclk,        // Clock from controller
   input  wire logic        memCkEn,     // Clock enable
   input  wire logic        memCsn,      // Select, low active
   input  wire logic [9:0]  memCaRise,   // CA rising half
   input  wire logic [9:0]  memCaFall,   // CA falling half
   input  wire logic [31:0] memDqOut,    // Write data
   input  wire logic [31:0] memDqOe,     // Write data enable
   input  wire logic [3:0]  memMask,     // Byte masks
   input  wire logic [3:0]  memStrobeOe, // Strobes driven by controller
   output logic      [31:0] memDqIn      // Read data
);
   logic [7:0]  mr [256];
   logic [31:0] mem [int];
   logic [16:0] rowKey;
   logic [8:0]  colBase;
   logic [31:0] word;
   logic        rowOpen = 1'b0;
   logic        apPend = 1'b0;
   int          beatIdx = 4, rdLeft = 0, wrWait = 0, refCount = 0, k;
   wire sel = !memCsn && memCkEn;
   initial memDqIn = 32'h0;
   always @(posedge mclk) begin
      if (rdLeft > 0) rdLeft--;
      if (wrWait > 0) wrWait--;
      // Released bus toggles so a late sample never matches by luck
      if (rdLeft >= 1 && rdLeft <= 4) memDqIn <= mem[{rowKey, colBase + 9'(4 - rdLeft)}];
      else memDqIn <= ~memDqIn;
      if (wrWait == 0 && beatIdx < 4 && memDqOe != 32'h0 && memStrobeOe != 4'h0) begin
         k = {rowKey, colBase + 9'(beatIdx)};
         word = mem.exists(k) ? mem[k] : 32'h0;
         for (int i = 0; i < 4; i++)
            if (!memMask[i]) word[8*i +: 8] = memDqOut[8*i +: 8];
         mem[k] = word;
         beatIdx++;
      end
      if (apPend && rdLeft <= 1 && beatIdx == 4) begin
         rowOpen = 1'b0;
         apPend = 1'b0;
      end
      if (sel && memCaRise[3:0] == 4'h0) mr[{memCaFall[1:0], memCaRise[9:4]}] = memCaFall[9:2];
      if (sel && memCaRise[1:0] == 2'h2) begin
         rowKey = {memCaRise[9:7], memCaFall[8], memCaRise[6:2], memCaFall[7:0]};
         rowOpen = 1'b1;
      end
      if (sel && memCaRise[1:0] == 2'h1) begin
         colBase = {memCaFall[6:1], memCaRise[6:5], 1'b0};
         rowKey[16:14] = memCaRise[9:7];
         apPend = memCaFall[0];
         if (memCaRise[2]) rdLeft = `LPCTL_RL_CYC + 4;
         else begin
            beatIdx = 0;
            wrWait = `LPCTL_WL_CYC;
         end
      end
      if (sel && memCaRise[3:0] == 4'hB && (memCaRise[4] || memCaRise[9:7] == rowKey[16:14])) rowOpen = 1'b0;
      if (sel && memCaRise[3:0] == 4'hC) refCount++;
   end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 1'b0, rstn = 1'b0, reqValid = 1'b0, wrValid = 1'b0;
   lpctl_pkg::lpctl_req_t  req = '0;
   lpctl_pkg::lpctl_beat_t wrBeat = '0;
   logic        reqReady, wrReady, rdValid, busy, memCkEn, memCsn;
   logic [31:0] rdData, memDqOut, memDqOe, memDqIn;
   logic [9:0]  memCaRise, memCaFall;
   logic [3:0]  memMask, memStrobe, memStrobeOe;
   logic [31:0] rdQ[$], expQ[$];
   int          err_total = 0, check_count = 0, lowRun = 0, lastLow = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (rdValid === 1'b1) rdQ.push_back(rdData);
   // Length of the last clock-enable low stretch, in cycles
   always @(posedge mclk) begin
      if (memCkEn === 1'b0) lowRun++;
      else if (lowRun != 0) begin
         lastLow = lowRun;
         lowRun = 0;
      end
   end
   // Short refresh and power-down counts keep the run brief
   lpctl_ctrl #(.REFI_CYC(40), .RASMAX_CYC(100), .DPD_CYC(20)) dut (.mclk(mclk), .rstn(rstn), .req(req),
      .reqValid(reqValid), .reqReady(reqReady), .wrBeat(wrBeat), .wrValid(wrValid), .wrReady(wrReady),
      .rdData(rdData), .rdValid(rdValid), .busy(busy), .memCkEn(memCkEn), .memCsn(memCsn),
      .memCaRise(memCaRise), .memCaFall(memCaFall), .memDqOut(memDqOut), .memDqOe(memDqOe),
      .memDqIn(memDqIn), .memMask(memMask), .memStrobe(memStrobe), .memStrobeOe(memStrobeOe));
   lpctl_dev_model dev (.mclk(mclk), .memCkEn(memCkEn), .memCsn(memCsn), .memCaRise(memCaRise),
      .memCaFall(memCaFall), .memDqOut(memDqOut), .memDqOe(memDqOe), .memMask(memMask),
      .memStrobeOe(memStrobeOe), .memDqIn(memDqIn));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic hang;
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      give_verdict;
   endtask
   task automatic issue(input lpctl_pkg::lpctl_req_t r, input bit settle);
      int n;
      @(posedge mclk);
      req <= r;
      reqValid <= 1'b1;
      n = 0;
      do @(negedge mclk); while (reqReady !== 1'b1 && ++n < 800);
      if (n >= 800) hang;
      @(posedge mclk);
      reqValid <= 1'b0;
      n = 0;
      if (settle) do @(negedge mclk); while (busy !== 1'b0 && ++n < 800);
      if (n >= 800) hang;
   endtask
   task automatic t_mrw;
      lpctl_pkg::lpctl_req_t r;
      r = '0;
      r.op = lpctl_pkg::LPCTL_OP_MRW;
      for (int i = 0; i < 2; i++) begin
         r.mrAddr = i ? 8'hC1 : 8'h3E;
         r.mrData = i ? 8'h96 : 8'h5A;
         issue(r, 1'b1);
         chk(32'(dev.mr[r.mrAddr]), 32'(r.mrData));
      end
   endtask
   // Fills the buffer to refusal, then drains it by writes each read back
   task automatic t_burst(input int half);
      lpctl_pkg::lpctl_req_t r;
      logic [31:0] d, e;
      logic [3:0]  m;
      int n;
      for (int i = 0; i < 16; i++) begin
         d = 32'(i + 16 * half) * 32'h0102_0409 + 32'h1357_9BDF;
         m = (i % 4 == 1) ? 4'(i) : 4'h0;
         for (int b = 0; b < 4; b++) e[8*b +: 8] = m[b] ? 8'h00 : d[8*b +: 8];
         expQ.push_back(e);
         @(posedge mclk);
         wrBeat <= {d, m};
         wrValid <= 1'b1;
         n = 0;
         do @(negedge mclk); while (wrReady !== 1'b1 && ++n < 100);
         if (n >= 100) hang;
      end
      @(posedge mclk);
      wrValid <= 1'b0;
      @(negedge mclk);
      chk(32'(wrReady), 32'h0);
      for (int w = 0; w < 4; w++) begin
         r = '0;
         r.op = lpctl_pkg::LPCTL_OP_WRITE;
         r.bank = 3'(2 * w + half);
         r.row = 14'h2000 | 14'(w * 71);
         r.col = 10'(w * 8) | 10'h001;
         r.autoPre = w[0];
         issue(r, 1'b1);
         chk(32'(dev.rowOpen), 32'h0);
         r.op = lpctl_pkg::LPCTL_OP_READ;
         r.col = 10'(w * 8);
         issue(r, 1'b1);
         n = 0;
         while (rdQ.size() < 4 && n++ < 100) @(negedge mclk);
         if (n > 100) hang;
         for (int k = 0; k < 4; k++) chk(rdQ.pop_front(), expQ.pop_front());
      end
   endtask
   task automatic t_power;
      lpctl_pkg::lpctl_req_t r;
      int n, c0;
      r = '0;
      c0 = dev.refCount;
      r.op = lpctl_pkg::LPCTL_OP_REFRESH;
      issue(r, 1'b1);
      chk(32'(dev.refCount > c0), 32'h1);
      for (int i = 0; i < 2; i++) begin
         r.op = i ? lpctl_pkg::LPCTL_OP_DEEPPD : lpctl_pkg::LPCTL_OP_SELFREF;
         issue(r, 1'b0);
         n = 0;
         do @(negedge mclk); while (memCkEn !== 1'b0 && ++n < 100);
         chk(32'(memCkEn), 32'h0);
         r.op = lpctl_pkg::LPCTL_OP_WAKE;
         issue(r, 1'b1);
         chk(32'(memCkEn), 32'h1);
         chk(32'(lastLow >= (i ? 20 : 3)), 32'h1);
      end
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      t_mrw;
      t_burst(0);
      t_burst(1);
      t_power;
      give_verdict;
   end
endmodule
`default_nettype wire
